// ---- hdl/acg_consts.svh ----
// Register offsets, field positions, reset values and unmapped read value of the frequency registers
`ifndef ACG_CONSTS_SVH
`define ACG_CONSTS_SVH

// Byte addresses of the first generator frequency registers
`define ACG_OFS_FREQ_HIGH 16'hFFE5
`define ACG_OFS_FREQ_MID 16'hFFE6
`define ACG_OFS_FREQ_LOW 16'hFFE7

// Reset value of every frequency byte
`define ACG_FREQ_BYTE_RESET 8'h00

// Reset value of the whole frequency word
`define ACG_FREQ_WORD_RESET 24'h000000

// Field positions of the bytes inside the 24-bit frequency word
`define ACG_FLD_LOW_LSB 0
`define ACG_FLD_MID_LSB 8
`define ACG_FLD_HIGH_LSB 16

// Value returned for an address outside this block
`define ACG_UNMAPPED_DATA 8'h00

`endif

// ---- hdl/acg_pkg.sv ----
// Types shared by the adaptive clock frequency register block
package acg_pkg;

    // One byte of a register
    typedef logic [7:0] acg_byte_t;

    // Complete frequency word of a synthesizer
    typedef logic [23:0] acg_word_t;

    // Source that drives the codec master clock output, one-hot
    typedef enum logic [1:0] {
        ACG_SRC_FIRST = 2'b01,
        ACG_SRC_SECOND = 2'b10
    } acg_src_t;

endpackage : acg_pkg

// ---- hdl/acg_freq_apply.sv ----
// Applies a complete frequency word and picks the codec master clock source
`timescale 1ns/10ps
`default_nettype none
`include "acg_consts.svh"

module acg_freq_apply
    import acg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic commit,
    input wire acg_word_t commitWord,
    input wire logic selectSecondSynth,
    input wire acg_word_t secondFreqWord,
    output acg_word_t firstFreqWord,
    output acg_word_t masterClockFreqWord,
    output acg_src_t masterClockSource,
    output logic freqUpdate
);

    // Source picked for the coming cycle
    wire acg_src_t next_source = selectSecondSynth ? ACG_SRC_SECOND : ACG_SRC_FIRST;

    // Word of the chosen synthesizer
    wire acg_word_t next_masterWord = selectSecondSynth ? secondFreqWord : firstFreqWord;

    // First synthesizer word changes only on a whole-word commit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            firstFreqWord <= `ACG_FREQ_WORD_RESET;
            freqUpdate <= 1'b0;
        end
        else if (clkEn)
        begin
            freqUpdate <= commit;
            if (commit)
            begin
                firstFreqWord <= commitWord; // RULE7
            end
        end
    end

    // Master clock word follows the chosen synthesizer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            masterClockFreqWord <= `ACG_FREQ_WORD_RESET;
            masterClockSource <= ACG_SRC_FIRST;
        end
        else if (clkEn)
        begin
            masterClockFreqWord <= next_masterWord; // RULE6
            masterClockSource <= next_source; // RULE6
        end
    end

    // Second synthesizer drives the master clock word when chosen
    property p_second_source;
        @(posedge clk) disable iff (!rst_n)
        clkEn && selectSecondSynth |=> masterClockFreqWord == $past(secondFreqWord)
            && masterClockSource == ACG_SRC_SECOND;
    endproperty
    a_second_source: assert property (p_second_source) else $error("second source not applied"); // RULE6

    // First synthesizer drives the master clock word otherwise
    property p_first_source;
        @(posedge clk) disable iff (!rst_n)
        clkEn && !selectSecondSynth |=> masterClockFreqWord == $past(firstFreqWord)
            && masterClockSource == ACG_SRC_FIRST;
    endproperty
    a_first_source: assert property (p_first_source) else $error("first source not applied"); // RULE5

    // Source switch seen
    property p_cov_switch;
        @(posedge clk) disable iff (!rst_n)
        clkEn && !selectSecondSynth ##1 clkEn && selectSecondSynth;
    endproperty
    c_cov_switch: cover property (p_cov_switch);

endmodule : acg_freq_apply
`default_nettype wire

// ---- hdl/acg_freq_regs.sv ----
// Frequency registers of the first adaptive clock generator
// Summary of operation
// RULE1: Low byte register holds word bits 7:0
// RULE2: Middle byte register holds word bits 15:8
// RULE3: High byte register holds word bits 23:16
// RULE4: Controller writes and reads all three bytes
// RULE5: Master clock frequency follows the 24-bit word
// RULE6: Master clock may come from second synthesizer
// RULE7: New word applied only as whole value
`timescale 1ns/10ps
`default_nettype none
`include "acg_consts.svh"

module acg_freq_regs
    import acg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [15:0] mcuAddr,
    input wire logic mcuWrite,
    input wire logic mcuRead,
    input wire acg_byte_t mcuWrData,
    input wire logic selectSecondSynth,
    input wire acg_word_t secondFreqWord,
    output acg_byte_t mcuRdData,
    output logic mcuRdHit,
    output acg_word_t firstFreqWord,
    output acg_word_t masterClockFreqWord,
    output acg_src_t masterClockSource,
    output logic freqUpdate
);

    // Stored frequency bytes as software sees them
    acg_byte_t freqLow;
    acg_byte_t freqMid;
    acg_byte_t freqHigh;

    // Address decode of the three registers
    wire logic hitLow = (mcuAddr == `ACG_OFS_FREQ_LOW);
    wire logic hitMid = (mcuAddr == `ACG_OFS_FREQ_MID);
    wire logic hitHigh = (mcuAddr == `ACG_OFS_FREQ_HIGH);
    wire logic hitAny = hitLow | hitMid | hitHigh;

    // Write strobes per register
    wire logic wrLow = mcuWrite & hitLow;
    wire logic wrMid = mcuWrite & hitMid;
    wire logic wrHigh = mcuWrite & hitHigh;

    // Read selection; unmapped addresses give a fixed value
    wire acg_byte_t next_rdData = hitLow ? freqLow :
                                  hitMid ? freqMid :
                                  hitHigh ? freqHigh : `ACG_UNMAPPED_DATA; // RULE4

    // Read hit flag for the coming cycle
    wire logic next_rdHit = mcuRead & hitAny;

    // Whole word as it stands after a high-byte write; commits it in one step
    wire acg_word_t commitWord = {mcuWrData, freqMid, freqLow}; // RULE5

    // Commit happens on the high-byte write that closes a programming sequence
    wire logic commit = wrHigh; // RULE7

    // Low byte register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            freqLow <= `ACG_FREQ_BYTE_RESET;
        end
        else if (clkEn && wrLow)
        begin
            freqLow <= mcuWrData; // RULE1
        end
    end

    // Middle byte register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            freqMid <= `ACG_FREQ_BYTE_RESET;
        end
        else if (clkEn && wrMid)
        begin
            freqMid <= mcuWrData; // RULE2
        end
    end

    // High byte register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            freqHigh <= `ACG_FREQ_BYTE_RESET;
        end
        else if (clkEn && wrHigh)
        begin
            freqHigh <= mcuWrData; // RULE3
        end
    end

    // Registered read port; data stands until the next enabled read
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mcuRdData <= `ACG_UNMAPPED_DATA;
            mcuRdHit <= 1'b0;
        end
        else if (clkEn)
        begin
            if (mcuRead)
            begin
                mcuRdData <= next_rdData; // RULE4
            end
            mcuRdHit <= next_rdHit;
        end
    end

    // Word application and master clock source selection
    acg_freq_apply u_acg_freq_apply (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .commit(commit),
        .commitWord(commitWord),
        .selectSecondSynth(selectSecondSynth),
        .secondFreqWord(secondFreqWord),
        .firstFreqWord(firstFreqWord),
        .masterClockFreqWord(masterClockFreqWord),
        .masterClockSource(masterClockSource),
        .freqUpdate(freqUpdate)
    );

    // Low byte write lands in word bits 7:0 of the stored value
    property p_low_byte;
        @(posedge clk) disable iff (!rst_n)
        clkEn && wrLow |=> freqLow == $past(mcuWrData);
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte not stored"); // RULE1

    // Middle byte write lands in word bits 15:8 after the next commit
    property p_mid_byte;
        @(posedge clk) disable iff (!rst_n)
        clkEn && wrMid ##1 clkEn && wrHigh |=> firstFreqWord[15:8] == $past(freqMid, 1);
    endproperty
    a_mid_byte: assert property (p_mid_byte) else $error("middle byte misplaced"); // RULE2

    // High byte write lands in word bits 23:16 together with the commit
    property p_high_byte;
        @(posedge clk) disable iff (!rst_n)
        clkEn && wrHigh |=> freqHigh == $past(mcuWrData)
            && firstFreqWord[23:16] == $past(mcuWrData);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high byte misplaced"); // RULE3

    // Applied word equals the three stored bytes after a commit, flagged by a pulse
    property p_whole_word;
        @(posedge clk) disable iff (!rst_n)
        clkEn && wrHigh |=> firstFreqWord == {freqHigh, freqMid, freqLow} && freqUpdate;
    endproperty
    a_whole_word: assert property (p_whole_word) else $error("applied word wrong"); // RULE5

    // Partial byte writes never retune the applied word
    property p_no_partial;
        @(posedge clk) disable iff (!rst_n)
        clkEn && (wrLow || wrMid) |=> $stable(firstFreqWord) && !freqUpdate;
    endproperty
    a_no_partial: assert property (p_no_partial) else $error("partial word applied"); // RULE7

    // Read of the middle register returns its stored byte next cycle
    property p_read_back;
        @(posedge clk) disable iff (!rst_n)
        clkEn && mcuRead && hitMid && !mcuWrite |=> mcuRdHit && mcuRdData == $past(freqMid);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read back wrong"); // RULE4

    // Unmapped read answers with the fixed value and no hit
    property p_read_unmapped;
        @(posedge clk) disable iff (!rst_n)
        clkEn && mcuRead && !hitAny |=> !mcuRdHit && mcuRdData == `ACG_UNMAPPED_DATA;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read wrong"); // RULE4

    // Read data stands until the next enabled read is taken
    property p_read_hold;
        @(posedge clk) disable iff (!rst_n)
        !(clkEn && mcuRead) |=> $stable(mcuRdData);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data not held"); // RULE4

    // Frozen enable keeps every stored byte and the applied word
    property p_stall_hold;
        @(posedge clk) disable iff (!rst_n)
        !clkEn |=> $stable(freqLow) && $stable(freqMid) && $stable(freqHigh)
            && $stable(firstFreqWord);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("state changed while frozen"); // RULE7

    // Update pulse only follows a committing high-byte write
    property p_update_pulse;
        @(posedge clk) disable iff (!rst_n)
        clkEn && !wrHigh |=> !freqUpdate;
    endproperty
    a_update_pulse: assert property (p_update_pulse) else $error("update without commit"); // RULE7

    // Full three-byte programming sequence
    property p_cov_program;
        @(posedge clk) disable iff (!rst_n)
        clkEn && wrLow ##1 clkEn && wrMid ##1 clkEn && wrHigh;
    endproperty
    c_cov_program: cover property (p_cov_program);

    // Read back after a write
    property p_cov_readback;
        @(posedge clk) disable iff (!rst_n)
        clkEn && wrHigh ##1 clkEn && mcuRead && hitHigh;
    endproperty
    c_cov_readback: cover property (p_cov_readback);

    // Clock enable stall during a write
    property p_cov_stall;
        @(posedge clk) disable iff (!rst_n)
        !clkEn && mcuWrite && hitAny;
    endproperty
    c_cov_stall: cover property (p_cov_stall);

endmodule : acg_freq_regs
`default_nettype wire

// ---- tb/tb_acg_freq_regs.sv ----
// Self-checking testbench of the first generator frequency registers
`timescale 1ns/10ps
`default_nettype none
`include "acg_consts.svh"

module tb_acg_freq_regs
    import acg_pkg::*;
;
    logic clk = 1'b0; // Bench clock, 8 ns period
    logic rst_n; // Synchronous reset, active low
    logic clkEn; // Clock enable
    logic [15:0] mcuAddr; // Controller byte address
    logic mcuWrite; // Write strobe
    logic mcuRead; // Read strobe
    acg_byte_t mcuWrData; // Write data
    logic selectSecondSynth; // Master clock source choice
    acg_word_t secondFreqWord; // Second synthesizer word
    acg_byte_t mcuRdData; // Read data
    logic mcuRdHit; // Read hit flag
    acg_word_t firstFreqWord; // Applied first word
    acg_word_t masterClockFreqWord; // Word feeding the master clock
    acg_src_t masterClockSource; // Selected source
    logic freqUpdate; // Commit pulse
    int nErrors = 0; // Mismatch count
    int nChecks = 0; // Comparison count
    int cycles = 0; // Clock cycles run
    int seed = 84; // Fixed random seed
    acg_byte_t lo, mi, hi; // Bytes of the current word
    acg_word_t applied; // Word the bench expects applied
    logic sel; // Random source choice

    // Clock generator
    always #4 clk = ~clk;

    acg_freq_regs u_acg_freq_regs (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .mcuAddr(mcuAddr),
        .mcuWrite(mcuWrite), .mcuRead(mcuRead), .mcuWrData(mcuWrData),
        .selectSecondSynth(selectSecondSynth), .secondFreqWord(secondFreqWord),
        .mcuRdData(mcuRdData), .mcuRdHit(mcuRdHit), .firstFreqWord(firstFreqWord),
        .masterClockFreqWord(masterClockFreqWord),
        .masterClockSource(masterClockSource), .freqUpdate(freqUpdate)
    );

    // Whole word from its three bytes
    function automatic acg_word_t expWord(input acg_byte_t h, input acg_byte_t m,
                                          input acg_byte_t l);
        return {h, m, l};
    endfunction : expWord

    // Compare a word or byte result
    task automatic chkw(input string nm, input logic [23:0] e, input logic [23:0] g);
        nChecks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            nErrors++;
        end
    endtask : chkw

    // Compare a flag or source code
    task automatic chkb(input string nm, input logic [1:0] e, input logic [1:0] g);
        nChecks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
            nErrors++;
        end
    endtask : chkb

    // One bus access; returns at the falling edge after the taking edge
    task automatic bus(input logic [15:0] a, input logic w, input acg_byte_t d);
        @(negedge clk);
        mcuAddr = a;
        mcuWrData = d;
        mcuWrite = w;
        mcuRead = ~w;
        @(negedge clk);
        mcuWrite = 1'b0;
        mcuRead = 1'b0;
    endtask : bus

    // Read a byte and compare data and hit flag
    task automatic readChk(input logic [15:0] a, input acg_byte_t e, input logic hit);
        bus(a, 1'b0, 8'h00);
        chkw("read data", {16'h0000, e}, {16'h0000, mcuRdData});
        chkb("read hit", {1'b0, hit}, {1'b0, mcuRdHit});
    endtask : readChk

    // Print counts and verdict, then stop
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // Cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            nErrors++;
            end_sim();
        end
    end

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        mcuAddr = 16'h0000;
        mcuWrite = 1'b0;
        mcuRead = 1'b0;
        mcuWrData = 8'h00;
        selectSecondSynth = 1'b0;
        secondFreqWord = 24'h000000;
        applied = 24'h000000;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chkw("first word", 24'h000000, firstFreqWord);
        chkb("source", ACG_SRC_FIRST, masterClockSource);
        readChk(`ACG_OFS_FREQ_LOW, 8'h00, 1'b1);
        readChk(`ACG_OFS_FREQ_MID, 8'h00, 1'b1);
        readChk(`ACG_OFS_FREQ_HIGH, 8'h00, 1'b1);
        $display("Test reset values done");
        // Random words, first one all ones
        for (int i = 0; i < 20; i++)
        begin
            lo = 8'($random(seed));
            mi = 8'($random(seed));
            hi = 8'($random(seed));
            if (i == 0)
                {hi, mi, lo} = 24'hFFFFFF;
            bus(`ACG_OFS_FREQ_LOW, 1'b1, lo);
            chkw("first word", applied, firstFreqWord);
            bus(`ACG_OFS_FREQ_MID, 1'b1, mi);
            chkw("first word", applied, firstFreqWord);
            bus(`ACG_OFS_FREQ_HIGH, 1'b1, hi);
            applied = expWord(hi, mi, lo);
            chkw("first word", applied, firstFreqWord);
            chkb("update", 2'b01, {1'b0, freqUpdate});
            @(negedge clk);
            chkw("master word", applied, masterClockFreqWord);
            chkb("update", 2'b00, {1'b0, freqUpdate});
            readChk(`ACG_OFS_FREQ_LOW, lo, 1'b1);
            readChk(`ACG_OFS_FREQ_MID, mi, 1'b1);
            readChk(`ACG_OFS_FREQ_HIGH, hi, 1'b1);
        end
        $display("Test word programming done");
        // Unmapped address is ignored
        bus(16'hFFE4, 1'b1, 8'hA5);
        readChk(16'hFFE4, 8'h00, 1'b0);
        chkw("first word", applied, firstFreqWord);
        // Frozen enable blocks a write
        clkEn = 1'b0;
        bus(`ACG_OFS_FREQ_HIGH, 1'b1, ~hi);
        clkEn = 1'b1;
        readChk(`ACG_OFS_FREQ_HIGH, hi, 1'b1);
        $display("Test refused accesses done");
        // Source selection between the two synthesizers
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            sel = 1'($random(seed));
            selectSecondSynth = sel;
            secondFreqWord = 24'($random(seed));
            @(negedge clk);
            chkb("source", sel ? ACG_SRC_SECOND : ACG_SRC_FIRST, masterClockSource);
            chkw("master word", sel ? secondFreqWord : applied, masterClockFreqWord);
        end
        selectSecondSynth = 1'b0;
        $display("Test source select done");
        // Reset in mid-run clears the word
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        chkw("first word", 24'h000000, firstFreqWord);
        chkw("master word", 24'h000000, masterClockFreqWord);
        readChk(`ACG_OFS_FREQ_HIGH, 8'h00, 1'b1);
        $display("Test second reset done");
        end_sim();
    end

endmodule : tb_acg_freq_regs

`default_nettype wire
